// [pkg/ipm_pkg.sv]
// package for the interrupt priority, mask, poll and end-of-service block
// Contract
// RQ1: block requests with level above threshold
// RQ2: threshold resets to seven, nothing blocked
// RQ3: master mask bit one masks, zero enables
// RQ4: master mask bits follow fixed source layout
// RQ5: master mask resets with all sources masked
// RQ6: slave mask layout fixed, resets 003Dh
// RQ7: slave mask shared with control mask bits
// RQ8: poll read acknowledges highest pending request
// RQ9: peek poll reads same, changes nothing
// RQ10: poll bit 15 flags a pending request
// RQ11: poll low five bits give type
// RQ12: master end-of-service write clears in-service
// RQ13: bit 15 selects nonspecific or specific clear
// RQ14: handler writes end-of-service before returning
// RQ15: slave end-of-service clears flag by level
// RQ16: slave type is vector upper plus level
// RQ17: vector register reads zero outside type
// RQ18: processor multiplies eight-bit type by four
// RQ19: taken interrupt sets in-service until cleared
// RQ20: master timer request ORs three timers
// RQ21: reserved bits read zero, writes ignored
package ipm_pkg;

  // register offsets as printed, used directly as port addresses
  localparam logic [7:0] OFS_VECTOR_BASE  = 8'h20;
  localparam logic [7:0] OFS_END_SERVICE  = 8'h22;
  localparam logic [7:0] OFS_ACK_POLL     = 8'h24;
  localparam logic [7:0] OFS_PEEK_POLL    = 8'h26;
  localparam logic [7:0] OFS_SOURCE_MASK  = 8'h28;
  localparam logic [7:0] OFS_PRIO_THRESH  = 8'h2A;

  // reset values
  localparam logic [2:0]  THRESH_RESET    = 3'h7;
  localparam logic [15:0] MASK_RESET_MSTR = 16'h07FD;
  localparam logic [15:0] MASK_RESET_SLV  = 16'h003D;
  localparam logic [4:0]  VEC_UPPER_RESET = 5'h00;

  // implemented mask bits per mode
  localparam logic [15:0] IMPL_MSTR       = 16'h07FD;
  localparam logic [15:0] IMPL_SLV        = 16'h003D;

  // master source bit positions
  localparam int BIT_SERIAL0  = 10;
  localparam int BIT_SERIAL1  = 9;
  localparam int BIT_EXT_LO   = 4;
  localparam int BIT_DMA1     = 3;
  localparam int BIT_DMA0     = 2;
  localparam int BIT_TIMER    = 0;
  // slave source bit positions
  localparam int BIT_TIMER2   = 5;
  localparam int BIT_TIMER1   = 4;
  localparam int BIT_TIMER0   = 0;

  // field positions
  localparam int POLL_REQ_BIT = 15;
  localparam int NONSPECIFIC_SELECT_BIT    = 15;
  localparam int VEC_LO       = 3;
  localparam int VEC_HI       = 7;

  // master-mode interrupt types per mask bit; plain defaults
  localparam logic [15:0][7:0] MSTR_TYPE_TBL = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h11, 8'h10,
    8'h0F, 8'h0E, 8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h00, 8'h08};

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ipm_bus_t;

  // raw source requests, one-cycle or level, from peripherals
  typedef struct packed {
    logic       serial0;
    logic       serial1;
    logic [4:0] ext;
    logic       dma1_or_ext6;
    logic       dma0_or_ext5;
    logic [2:0] timer;
  } ipm_src_t;

  // control-register mask write, indexed by mask bit position
  typedef struct packed {
    logic       wr;
    logic [3:0] bit_idx;
    logic       value;
  } ipm_ctl_mask_t;

endpackage : ipm_pkg

// [hdl/ipm_core.sv]
// interrupt controller register core: threshold, masks, poll, end-of-service
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ipm_core (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   slave_mode,
  input  wire ipm_pkg::ipm_bus_t      bus,
  output var  logic [15:0]            rdata,
  input  wire ipm_pkg::ipm_src_t      src,
  input  wire logic [15:0][2:0]       src_level,
  input  wire ipm_pkg::ipm_ctl_mask_t ctl_mask,
  input  wire logic                   hw_ack,
  output var  logic                   int_request,
  output var  logic [7:0]             int_type,
  output var  logic [15:0]            mask_state,
  output var  logic [15:0]            in_service_flags
);
  import ipm_pkg::*;

  // block layout, top to bottom: port decode, raw request map
  // per mode, threshold and mask gating, winner pick, poll word,
  // end-of-service decode, next-state, then the flops
  // every output is a flop, so timing at the ports stays simple
  // limitation: one register port, no byte lanes, 16-bit words

  // lowest level number wins, lowest bit breaks ties
  // the scan runs from the top bit down so that an equal level
  // met later, at a lower bit, takes over the choice
  // bit 4 of the result flags an empty candidate set
  function automatic logic [4:0] pick_best(input logic [15:0] cand, input logic [15:0][2:0] lvl);
    logic [4:0] best;
    best = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (cand[i] && (best[4] || lvl[i] <= lvl[best[3:0]])) begin
        best = {1'b0, 4'(i)};
      end
    end
    return best;
  endfunction : pick_best

  // state
  // each register but int_req_r and int_type_r has a _nxt twin from a comb block, which
  // keeps the clocked processes down to plain copies
  logic [2:0]  thresh_r;        // threshold_field
  logic [2:0]  thresh_nxt;
  logic [15:0] mask_r;          // shared source mask
  logic [15:0] mask_nxt;
  logic [4:0]  vec_upper_r;     // vector_upper_type
  logic [4:0]  vec_upper_nxt;
  logic [15:0] pend_r;          // latched requests
  logic [15:0] pend_nxt;
  logic [15:0] insrv_r;         // in_service_flags
  logic [15:0] insrv_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        int_req_r;
  logic [7:0]  int_type_r;

  // decode
  // strobes qualify the address once here, so every later term but the
  // read mux relies on a single clean select per register
  // impl follows the mode pin; bits outside it are reserved
  wire         wr_eos    = bus.wr && bus.addr == OFS_END_SERVICE;
  wire         wr_mask   = bus.wr && bus.addr == OFS_SOURCE_MASK;
  wire         wr_thresh = bus.wr && bus.addr == OFS_PRIO_THRESH;
  wire         wr_vector = bus.wr && bus.addr == OFS_VECTOR_BASE;
  wire         rd_poll   = bus.rd && bus.addr == OFS_ACK_POLL;
  wire [15:0]  impl      = slave_mode ? IMPL_SLV : IMPL_MSTR;

  // raw request vector per mode
  // both modes share the dma bits but map the timers apart:
  // master folds all timers into one bit, slave gives each its own
  // unused positions stay zero so they can never win
  logic [15:0] raw_mstr;
  logic [15:0] raw_slv;
  always_comb begin
    raw_mstr = 16'h0000;
    raw_mstr[BIT_SERIAL0] = src.serial0;
    raw_mstr[BIT_SERIAL1] = src.serial1;
    raw_mstr[BIT_EXT_LO +: 5] = src.ext;
    raw_mstr[BIT_DMA1] = src.dma1_or_ext6;
    raw_mstr[BIT_DMA0] = src.dma0_or_ext5;
    raw_mstr[BIT_TIMER] = |src.timer;  // see RQ20
    raw_slv = 16'h0000;
    raw_slv[BIT_TIMER2] = src.timer[2];
    raw_slv[BIT_TIMER1] = src.timer[1];
    raw_slv[BIT_DMA1] = src.dma1_or_ext6;
    raw_slv[BIT_DMA0] = src.dma0_or_ext5;
    raw_slv[BIT_TIMER0] = src.timer[0];
  end
  wire [15:0] raw_req = slave_mode ? raw_slv : raw_mstr;

  // threshold gate: level numerically above field is blocked
  // levels come from control registers outside this core;
  // the compare is inclusive, so a field of seven passes all
  logic [15:0] lvl_ok;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      lvl_ok[i] = src_level[i] <= thresh_r;  // see RQ1
    end
  end

  // eligible = pending, implemented, unmasked, within threshold
  // in-service sources are not excluded here: nesting policy
  // belongs to the arbitration outside this block
  wire [15:0] elig     = pend_r & impl & ~mask_r & lvl_ok;  // see RQ3 RQ1
  wire [4:0]  best     = pick_best(elig, src_level);
  wire        any_elig = ~best[4];
  wire [3:0]  best_idx = best[3:0];

  // winning type: table in master, vector plus level in slave
  // with nothing eligible the index falls to zero; the poll word
  // hides that type and int_request tells the core to ignore it
  wire [7:0]  win_type = slave_mode ? {vec_upper_r, src_level[best_idx]}  // see RQ16
                                    : MSTR_TYPE_TBL[best_idx];
  // poll word shared by both poll registers, reserved bits zero
  wire [15:0] poll_word = {any_elig, 10'h000, any_elig ? win_type[4:0] : 5'h00};  // see RQ10 RQ11 RQ21

  // acknowledge from poll read or hardware cycle
  // both paths feed one one-hot vector, so a poll read and a
  // hardware acknowledge in one cycle still take a single source
  wire        ack_take = (rd_poll || hw_ack) && any_elig;  // see RQ8
  wire [15:0] ack_hot  = ack_take ? (16'h0001 << best_idx) : 16'h0000;

  // end-of-service clear decode
  // nonspecific picks the best in-service flag by level;
  // specific matches the low type bits against the master table;
  // slave clears every implemented source at the written level
  // reserved write bits are simply not looked at
  wire [4:0]  ns_best  = pick_best(insrv_r, src_level);
  logic [15:0] eos_clr;
  always_comb begin
    eos_clr = 16'h0000;
    if (wr_eos && !slave_mode && bus.wdata[NONSPECIFIC_SELECT_BIT]) begin
      // nonspecific: drop highest in-service
      if (!ns_best[4]) begin
        eos_clr[ns_best[3:0]] = 1'b1;  // see RQ12 RQ13
      end
    end else if (wr_eos && !slave_mode) begin
      // specific: drop source whose type matches
      for (int i = 0; i < 16; i++) begin
        eos_clr[i] = IMPL_MSTR[i] && MSTR_TYPE_TBL[i][4:0] == bus.wdata[4:0];  // see RQ13
      end
    end else if (wr_eos) begin
      // slave: drop by level
      for (int i = 0; i < 16; i++) begin
        eos_clr[i] = IMPL_SLV[i] && src_level[i] == bus.wdata[2:0];  // see RQ15
      end
    end
  end

  // next-state
  // control-register mask writes come after the port write, so
  // a clash on one bit leaves the control-register value
  always_comb begin
    thresh_nxt    = wr_thresh ? bus.wdata[2:0] : thresh_r;  // see RQ1 RQ21
    vec_upper_nxt = wr_vector ? bus.wdata[VEC_HI:VEC_LO] : vec_upper_r;  // see RQ16
    mask_nxt      = mask_r;
    if (wr_mask) begin
      // only implemented bits of this mode are touched
      mask_nxt = (mask_r & ~impl) | (bus.wdata & impl);  // see RQ3 RQ4 RQ6 RQ21
    end
    if (ctl_mask.wr) begin
      // control-register mask bit lands in the same state
      mask_nxt[ctl_mask.bit_idx] = ctl_mask.value;  // see RQ7
    end
    // new requests win over an acknowledge in the same cycle
    pend_nxt  = (pend_r & ~ack_hot) | raw_req;
    // a take wins over a clear in the same cycle
    insrv_nxt = (insrv_r & ~eos_clr) | ack_hot;  // see RQ19
  end

  // read mux; peek has no side effect
  // data are zero unless a read is strobed, which keeps the port
  // quiet and lets a wired-or bus merge several slaves
  always_comb begin
    rdata_nxt = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        OFS_VECTOR_BASE: rdata_nxt = {8'h00, vec_upper_r, 3'h0};  // see RQ17
        OFS_ACK_POLL:    rdata_nxt = poll_word;                    // see RQ8
        OFS_PEEK_POLL:   rdata_nxt = poll_word;                    // see RQ9
        OFS_SOURCE_MASK: rdata_nxt = mask_r & impl;                // see RQ21
        OFS_PRIO_THRESH: rdata_nxt = {13'h0000, thresh_r};        // see RQ21
        default:         rdata_nxt = 16'h0000;  // write-only and unmapped read zero
      endcase
    end
  end

  // mask reset: one value covers both modes, slave view is its low bits
  // vector upper bits have no defined reset; zero is chosen so a
  // stray slave type stays predictable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      thresh_r    <= THRESH_RESET;     // see RQ2
      mask_r      <= MASK_RESET_MSTR;  // see RQ5 RQ6
      vec_upper_r <= VEC_UPPER_RESET;
    end else begin
      thresh_r    <= thresh_nxt;
      mask_r      <= mask_nxt;
      vec_upper_r <= vec_upper_nxt;
    end
  end

  // request and service state
  // nothing pending and nothing in service out of reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_r  <= 16'h0000;
      insrv_r <= 16'h0000;
    end else begin
      pend_r  <= pend_nxt;
      insrv_r <= insrv_nxt;
    end
  end

  // registered outputs
  // request and type trail the winner by one cycle; a poll read
  // in that cycle already sees the newer state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r    <= 16'h0000;
      int_req_r  <= 1'b0;
      int_type_r <= 8'h00;
    end else begin
      rdata_r    <= rdata_nxt;
      int_req_r  <= any_elig;
      int_type_r <= win_type;  // processor scales by four, see RQ18
    end
  end

  // ports are plain copies of flops, no logic past the registers
  // mask and in-service views let the core and a debugger look in
  assign rdata            = rdata_r;
  assign int_request      = int_req_r;
  assign int_type         = int_type_r;
  assign mask_state       = mask_r;
  assign in_service_flags = insrv_r;

  // checks
  // all on the system clock and quiet while reset is low
  // they watch internal terms as well as the ports, so a fault
  // is caught where it starts rather than where it shows
  // none of them constrains the inputs
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_poll_take;
    rd_poll && any_elig && !hw_ack;
  endsequence

  sequence s_peek_only;
    bus.rd && bus.addr == OFS_PEEK_POLL && !hw_ack && raw_req == 16'h0000 && !bus.wr;
  endsequence

  a_thresh_write: assert property (wr_thresh |=> thresh_r == $past(bus.wdata[2:0]))  // see RQ1
    else $error("threshold write not stored");
  a_thresh_block: assert property (int_req_r |-> $past(src_level[best_idx]) <= $past(thresh_r))  // see RQ1
    else $error("request above threshold raised");
  a_mask_write: assert property (wr_mask && !ctl_mask.wr |=> (mask_r & impl) == $past(bus.wdata & impl))  // see RQ3
    else $error("mask write not stored");
  a_ctl_mirror: assert property (ctl_mask.wr |=> mask_r[$past(ctl_mask.bit_idx)] == $past(ctl_mask.value))  // see RQ7
    else $error("control mask not mirrored");
  a_poll_ack: assert property (s_poll_take |=> insrv_r[$past(best_idx)] && rdata[POLL_REQ_BIT])  // see RQ8
    else $error("poll read did not acknowledge");
  a_peek_still: assert property (s_peek_only |=> insrv_r == $past(insrv_r) ##0 rdata == $past(poll_word))  // see RQ9
    else $error("peek changed state");
  a_poll_flag: assert property (bus.rd && bus.addr == OFS_ACK_POLL |=> rdata[POLL_REQ_BIT] == $past(any_elig))  // see RQ10
    else $error("poll flag wrong");
  a_eos_clear: assert property (wr_eos && !ack_take |=> (insrv_r & $past(eos_clr)) == 16'h0000)  // see RQ12 RQ15
    else $error("end of service left flag");
  a_vec_read: assert property (bus.rd && bus.addr == OFS_VECTOR_BASE |=> rdata[15:8] == 8'h00 && rdata[2:0] == 3'h0)  // see RQ17
    else $error("vector reserved bits set");
  a_slv_type: assert property (slave_mode && any_elig |=> int_type[7:3] == $past(vec_upper_r))  // see RQ16
    else $error("slave type upper bits wrong");

  // further checks, one behaviour each; five causes with several
  // terms are named as sequences, and each property but a_mask_quiet reads
  // as a cause and the effect one clock later

  // hardware acknowledge with no poll read beside it
  sequence s_hw_take;
    hw_ack && any_elig && !rd_poll;
  endsequence

  // nonspecific end-of-service with a flag set and no take
  sequence s_nonspecific_select_eos;
    wr_eos && !slave_mode && bus.wdata[NONSPECIFIC_SELECT_BIT] && !ack_take && insrv_r != 16'h0000;
  endsequence

  // acknowledge of a source that is not requesting again
  sequence s_ack_clean;
    ack_take && !raw_req[best_idx];
  endsequence

  // cycle with no end-of-service write and no acknowledge
  sequence s_service_idle;
    !wr_eos && !ack_take;
  endsequence

  // mask write that no control-register write overrides
  sequence s_mask_only;
    wr_mask && !ctl_mask.wr;
  endsequence

  // the read port idles at zero outside the answer cycle
  a_rdata_idle: assert property (!bus.rd |=> rdata == 16'h0000)  // see RQ21
    else $error("read data not idle");

  // peek returns the poll word of the strobe cycle
  a_peek_rd: assert property (bus.rd && bus.addr == OFS_PEEK_POLL |=> rdata == $past(poll_word))  // see RQ9
    else $error("peek word wrong");

  // poll type field follows the winner
  a_poll_type: assert property (rd_poll && any_elig |=> rdata[4:0] == $past(win_type[4:0]))  // see RQ11
    else $error("poll type wrong");

  // threshold reads back in the low field, zero above
  a_thresh_read: assert property (bus.rd && bus.addr == OFS_PRIO_THRESH  // see RQ21
    |=> rdata == {13'h0000, $past(thresh_r)})
    else $error("threshold read wrong");

  // mask reads show only the bits of the current mode
  a_mask_read: assert property (bus.rd && bus.addr == OFS_SOURCE_MASK |=> rdata == $past(mask_r & impl))  // see RQ21
    else $error("mask read wrong");

  // a port write leaves reserved mask bits alone
  a_mask_resv: assert property (s_mask_only |=> (mask_r & ~impl) == $past(mask_r & ~impl))  // see RQ21
    else $error("reserved mask bits written");

  // vector write keeps the upper type bits
  a_vec_write: assert property (wr_vector |=> vec_upper_r == $past(bus.wdata[VEC_HI:VEC_LO]))  // see RQ16
    else $error("vector write not stored");

  // any master timer sets the shared timer bit
  a_timer_or: assert property (!slave_mode && |src.timer |=> pend_r[BIT_TIMER])  // see RQ20
    else $error("timer group not set");

  // hardware acknowledge marks the winner in service
  a_hw_take: assert property (s_hw_take |=> insrv_r[$past(best_idx)])  // see RQ19
    else $error("hardware take not in service");

  // an acknowledged source moves on unless it asks again
  a_pend_clear: assert property (s_ack_clean |=> !pend_r[$past(best_idx)])  // see RQ8
    else $error("acknowledged request still pending");

  // in-service flags hold until a take or a clear
  a_insrv_hold: assert property (s_service_idle |=> insrv_r == $past(insrv_r))  // see RQ19
    else $error("in-service changed on its own");

  // no request is raised for a masked winner
  a_mask_quiet: assert property (int_req_r |-> !$past(mask_r[best_idx]))  // see RQ3
    else $error("masked source raised request");

  // slave type low bits carry the winner's level
  a_slv_level: assert property (slave_mode && any_elig |=> int_type[2:0] == $past(src_level[best_idx]))  // see RQ16
    else $error("slave type level wrong");

  // nonspecific clear drops exactly one flag
  a_nonspecific_select_one: assert property (s_nonspecific_select_eos |=> $countones(insrv_r) == $countones($past(insrv_r)) - 1)  // see RQ13
    else $error("nonspecific clear count wrong");

  // master type follows the source table
  a_int_type: assert property (!slave_mode && any_elig |=> int_type == $past(MSTR_TYPE_TBL[best_idx]))  // see RQ11
    else $error("master type wrong");

  // request line follows an eligible source
  a_req_flag: assert property (any_elig |=> int_request)  // see RQ10
    else $error("request line not raised");

endmodule : ipm_core
`default_nettype wire

// [verif/ipm_cpu_model.sv]
// processor core and peripheral model facing the interrupt register core
`timescale 1ns/1ps
`default_nettype none
module ipm_cpu_model (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire ipm_pkg::ipm_src_t fire,
  input  wire logic             take,
  input  wire logic             int_request,
  input  wire logic [7:0]       int_type,
  output var  ipm_pkg::ipm_src_t src,
  output var  logic             hw_ack,
  output var  logic [9:0]       vec_ofs
);
  import ipm_pkg::*;

  // peripherals pulse for one cycle, lines idle low between events
  // core acknowledges only while a request stands, so no stray ack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src     <= '0;
      hw_ack  <= 1'b0;
      vec_ofs <= '0;
    end else begin
      src    <= fire;
      hw_ack <= take & int_request;
      // table offset is the type times four
      if (take & int_request) begin
        vec_ofs <= {int_type, 2'b00};
      end
    end
  end
endmodule : ipm_cpu_model
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the interrupt register core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ipm_pkg::*;
  logic             clk_sys;
  logic             rstn;
  logic             slave_mode;
  ipm_bus_t         bus;
  logic [15:0]      rdata;
  ipm_src_t         src;
  ipm_src_t         fire;
  logic [15:0][2:0] src_level;
  ipm_ctl_mask_t    ctl_mask;
  logic             hw_ack;
  logic             take;
  logic             int_request;
  logic [7:0]       int_type;
  logic [15:0]      mask_state;
  logic [15:0]      isf;
  logic [9:0]       vec_ofs;
  int               fail_count;
  int               samples_checked;
  int               cyc;

  ipm_core uut (.clk_sys(clk_sys), .rstn(rstn), .slave_mode(slave_mode), .bus(bus), .rdata(rdata),
    .src(src), .src_level(src_level), .ctl_mask(ctl_mask), .hw_ack(hw_ack), .int_request(int_request),
    .int_type(int_type), .mask_state(mask_state), .in_service_flags(isf));
  ipm_cpu_model cpu (.clk_sys(clk_sys), .rstn(rstn), .fire(fire), .take(take),
    .int_request(int_request), .int_type(int_type), .src(src), .hw_ack(hw_ack), .vec_ofs(vec_ofs));

  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // verdict, reached from the main sequence or the hang guard
  task automatic wrap_up;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask : rd

  // pulse sources, then let pending and request settle
  task automatic pulse(input ipm_src_t s);
    @(posedge clk_sys);
    fire <= s;
    @(posedge clk_sys);
    fire <= '0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse

  // core takes the standing interrupt
  task automatic ack_hw;
    @(posedge clk_sys);
    take <= 1'b1;
    @(posedge clk_sys);
    take <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : ack_hw

  // hang guard, a little over a hundred cycles expected
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rstn = 1'b0;
    slave_mode = 1'b0;
    bus = '0;
    fire = '0;
    take = 1'b0;
    ctl_mask = '0;
    src_level = '0;
    fail_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    src_level[10] <= 3'd2;
    src_level[9] <= 3'd4;
    src_level[0] <= 3'd1;
    src_level[5] <= 3'd6;
    rd(8'h2A, 16'h0007, "thresh_rst");
    rd(8'h28, 16'h07FD, "mask_rst");
    chk("mask_state_rst", 16'h07FD, mask_state);
    wr(8'h2A, 16'hFFFF);
    rd(8'h2A, 16'h0007, "thresh_resv");
    wr(8'h28, 16'hFFFF);
    rd(8'h28, 16'h07FD, "mask_layout");
    wr(8'h28, 16'h0000);
    wr(8'h2A, 16'h0003);
    // serial1 sits above the threshold and must wait
    pulse(12'hC00);
    rd(8'h26, 16'h8014, "peek");
    rd(8'h26, 16'h8014, "peek_again");
    rd(8'h24, 16'h8014, "poll");
    chk("in_service_flags_poll", 16'h0400, isf);
    rd(8'h26, 16'h0000, "peek_blocked");
    wr(8'h2A, 16'h0007);
    rd(8'h26, 16'h8011, "peek_thresh");
    rd(8'h24, 16'h8011, "poll2");
    wr(8'h22, 16'h0014);
    chk("eoi_spec", 16'h0200, isf);
    // timer group via hardware acknowledge
    pulse(12'h002);
    chk("timer_type", 16'h0008, {8'h00, int_type});
    chk("int_req", 16'h0001, {15'h0000, int_request});
    ack_hw();
    chk("vec_ofs", 16'h0020, {6'h00, vec_ofs});
    chk("in_service_flags_hw", 16'h0201, isf);
    chk("int_req_drop", 16'h0000, {15'h0000, int_request});
    wr(8'h22, 16'h8000);
    chk("eoi_nonspecific_select", 16'h0200, isf);
    wr(8'h22, 16'h0011);
    chk("eoi_last", 16'h0000, isf);
    // masked source stays latched until enabled
    wr(8'h28, 16'h0400);
    pulse(12'h800);
    rd(8'h26, 16'h0000, "masked");
    wr(8'h28, 16'h0000);
    rd(8'h26, 16'h8014, "unmasked");
    rd(8'h24, 16'h8014, "poll3");
    wr(8'h22, 16'h0014);
    chk("eoi_clear", 16'h0000, isf);
    // slave mode mapping
    @(posedge clk_sys);
    slave_mode <= 1'b1;
    wr(8'h28, 16'hFFFF);
    rd(8'h28, 16'h003D, "slave_mask");
    wr(8'h28, 16'h0000);
    @(posedge clk_sys);
    ctl_mask <= '{wr: 1'b1, bit_idx: 4'h4, value: 1'b1};
    @(posedge clk_sys);
    ctl_mask <= '0;
    rd(8'h28, 16'h0010, "ctl_mirror");
    chk("mask_state", 16'h0010, mask_state);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h00F8, "vector");
    pulse(12'h004);
    chk("slave_type", 16'h00FE, {8'h00, int_type});
    rd(8'h24, 16'h801E, "slave_poll");
    chk("slave_in_service_flags", 16'h0020, isf);
    wr(8'h22, 16'h0005);
    chk("eoi_wrong_lvl", 16'h0020, isf);
    wr(8'h22, 16'h0006);
    chk("eoi_lvl", 16'h0000, isf);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
